/* common/loop_sync_pkg.sv */
// package: register map, line modes, carrier types and timing constants of the loopback block
package loop_sync_pkg;

    // operating line modes, gray coded along t1 -> e1 -> 6312 -> 64k
    typedef enum logic [1:0] {
        mode_t1 = 2'h0,
        mode_e1 = 2'h1,
        mode_sq6312 = 2'h3,
        mode_cc64 = 2'h2
    } line_mode_e;

    // one bipolar line sample: positive and negative rail
    typedef struct packed {
        logic pos;
        logic neg;
    } ami_s;

    // register bus widths and offsets
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] LOOP_CTRL_ADDR = 8'h20;
    localparam logic [7:0] STATUS_ADDR = 8'h21;
    localparam logic [7:0] SYNC_CFG_ADDR = 8'h22;
    localparam logic [7:0] LOOP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SYNC_CFG_RESET = 8'h00;

    // field positions
    localparam int REMOTE_LOOP_BIT = 2;
    localparam int LOCAL_LOOP_BIT = 3;
    localparam int CC400_BIT = 0;
    localparam int JA_EN_BIT = 1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_JA_BIT = 2;
    localparam int ST_SDATA_BIT = 3;
    localparam int ST_RX8K_BIT = 4;
    localparam int ST_RX400_BIT = 5;

    // timing: 20 MHz system clock against the composite clock rates
    localparam int CLOCK_HZ = 20000000;
    localparam int CC_BIT_HZ = 64000;
    localparam int CC_FRAME_HZ = 8000;
    localparam int CC_SUPER_HZ = 400;
    localparam int SQ_HZ = 6312000;
    localparam int CC_BIT_CYCLES = CLOCK_HZ / CC_BIT_HZ;
    localparam logic [8:0] CC_BIT_LAST = 9'(CC_BIT_CYCLES - 1);
    localparam logic [8:0] CC_HALF = 9'(CC_BIT_CYCLES / 2);
    localparam logic [2:0] CC_BIT_IDX_LAST = 3'(CC_BIT_HZ / CC_FRAME_HZ - 1);
    localparam logic [4:0] CC_FRAME_LAST = 5'(CC_FRAME_HZ / CC_SUPER_HZ - 1);
    localparam logic [3:0] RX_MISS_MARKS = 4'(CC_BIT_HZ / CC_FRAME_HZ - 1);
    localparam logic [31:0] NCO_INC = 32'((64'(SQ_HZ) << 32) / 64'(CLOCK_HZ));

endpackage

/* rtl/loop_sync_interface.sv */
// loopback control and synchronisation-clock line modes of the line interface unit
//
// Overview of operation
// R1: remote loop bit sends line receive to transmit
// R2: framer still sees receive; formatter data dropped
// R3: local loop replaces receive with transmit data
// R4: local loop path passes jitter attenuator when enabled
// R5: software writes zero to unused loop bits
// R6: composite mode: AMI, 8k violation, 400Hz omission
// R7: composite variants: with or without 400Hz
// R8: receive recovers 64k, 8k and 400Hz references
// R9: transmit violations align to 8k sync input
// R10: no sync input: free-running 8k violations
// R11: 6312 mode transmits square wave clock
// R12: 6312 receive accepts square or sine input
// R13: 6312 receive clock follows received signal
// R14: 6312 mode: 8k and 400Hz outputs three-stated
// R15: 6312 pll clock output is 50% square wave
// R16: 6312 transmit clock mirrors pll, remote loop: receive
// R17: 6312 mode ignores serial data and sync input
// R18: 6312 mode three-states both transmit line outputs
// R19: jitter attenuator only in t1 and e1 modes
// R20: line mode comes from outside, one only
// R21: both loop bits reset to zero
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module loop_sync_interface (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // configuration from the device level
    input wire loop_sync_pkg::line_mode_e line_mode,
    // line pins
    input wire loop_sync_pkg::ami_s line_rx,
    output loop_sync_pkg::ami_s line_tx,
    output logic line_tx_oe,
    // framer and formatter side
    input wire loop_sync_pkg::ami_s tx_fmt,
    output loop_sync_pkg::ami_s rx_frm,
    // sync pins
    input wire logic serial_data_in,
    input wire logic tx_sync_8k_in,
    output logic rx_sync_8k_out,
    output logic rx_sync_8k_oe,
    output logic rx_400hz_out,
    output logic rx_400hz_oe,
    // clock outputs
    output logic rx_clock_out,
    output logic tx_clock_out,
    output logic pll_clock_out
);

    // ****************************************
    // registers and mode
    // ****************************************
    logic [7:0] loop_ctrl_reg; // loopback control, only bits 2 and 3 stored
    logic [7:0] sync_cfg_reg; // composite variant and attenuator enable
    loop_sync_pkg::line_mode_e mode_reg; // registered line mode
    logic remote_loop; // remote loopback enabled
    logic local_loop; // local loopback enabled
    logic is_cc; // composite clock mode
    logic is_sq; // 6312 kHz mode
    logic ja_active; // attenuator really in the path

    assign remote_loop = loop_ctrl_reg[loop_sync_pkg::REMOTE_LOOP_BIT];
    assign local_loop = loop_ctrl_reg[loop_sync_pkg::LOCAL_LOOP_BIT];
    assign is_cc = (mode_reg == loop_sync_pkg::mode_cc64);
    assign is_sq = (mode_reg == loop_sync_pkg::mode_sq6312);
    // attenuator exists only for t1 and e1 lines
    assign ja_active = sync_cfg_reg[loop_sync_pkg::JA_EN_BIT] && !is_cc && !is_sq; // R19

    // line mode taken each cycle; one encoding means one mode
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_reg <= loop_sync_pkg::mode_t1;
        end else begin
            mode_reg <= line_mode; // R20
        end
    end

    // register writes; unused loop bits are never stored, so a stray one cannot act
    always_ff @(posedge clock) begin
        if (reset) begin
            loop_ctrl_reg <= loop_sync_pkg::LOOP_CTRL_RESET; // R21
            sync_cfg_reg <= loop_sync_pkg::SYNC_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == loop_sync_pkg::LOOP_CTRL_ADDR) begin
                loop_ctrl_reg <= reg_wdata & 8'h0c; // R5
            end
            if (reg_addr == loop_sync_pkg::SYNC_CFG_ADDR) begin
                sync_cfg_reg <= reg_wdata & 8'h03;
            end
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    loop_sync_pkg::ami_s rx_s1, rx_s2, rx_s3; // line receive, stage 3 for edges
    logic sync_s1, sync_s2, sync_s3; // transmit 8k sync pin
    logic sdata_s1, sdata_s2; // serial data pin

    // two flops before any use; third stage only for edge detection
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
            rx_s3 <= '0;
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
            sdata_s1 <= 1'b0;
            sdata_s2 <= 1'b0;
        end else begin
            rx_s1 <= line_rx;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            sync_s1 <= tx_sync_8k_in;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            sdata_s1 <= serial_data_in;
            sdata_s2 <= sdata_s1;
        end
    end

    // ****************************************
    // composite clock transmitter
    // ****************************************
    logic [8:0] cc_cnt; // cycles inside one 64k bit
    logic [2:0] cc_bit; // bit inside the 8k frame
    logic [4:0] cc_frame; // frame inside the 400 Hz superframe
    logic cc_pol; // polarity of last mark sent
    logic sync_edge; // rising edge of the 8k reference
    logic cc_viol_due; // this bit carries a violation
    loop_sync_pkg::ami_s cc_tx; // composite line symbol

    // the sync pin is not looked at in 6312 mode
    assign sync_edge = sync_s2 && !sync_s3 && is_cc; // R17
    // the violation is skipped once per superframe in the 400 Hz variant
    assign cc_viol_due = (cc_bit == 3'h0) &&
        !(sync_cfg_reg[loop_sync_pkg::CC400_BIT] && cc_frame == loop_sync_pkg::CC_FRAME_LAST); // R7

    // bit, frame and superframe counters; a reference edge restarts the frame
    always_ff @(posedge clock) begin
        if (reset || sync_edge) begin
            cc_cnt <= 9'h000; // R9
            cc_bit <= 3'h0;
            cc_frame <= 5'h00;
        end else if (cc_cnt == loop_sync_pkg::CC_BIT_LAST) begin
            // free running when no reference arrives
            cc_cnt <= 9'h000; // R10
            cc_bit <= cc_bit + 3'h1;
            if (cc_bit == loop_sync_pkg::CC_BIT_IDX_LAST) begin
                cc_frame <= (cc_frame == loop_sync_pkg::CC_FRAME_LAST) ? 5'h00 : cc_frame + 5'h01;
            end
        end else begin
            cc_cnt <= cc_cnt + 9'h001;
        end
    end

    // every bit is a mark; alternate polarity except at a violation
    always_ff @(posedge clock) begin
        if (reset) begin
            cc_pol <= 1'b0;
        end else if (cc_cnt == 9'h000 && !cc_viol_due) begin
            cc_pol <= !cc_pol; // R6
        end
    end

    // half-width marks start one cycle into the bit, once the new polarity has settled;
    // starting at count 0 would show a one-cycle spike of the old polarity
    assign cc_tx.pos = (cc_cnt != 9'h000) && (cc_cnt <= loop_sync_pkg::CC_HALF) && cc_pol;
    assign cc_tx.neg = (cc_cnt != 9'h000) && (cc_cnt <= loop_sync_pkg::CC_HALF) && !cc_pol;

    // ****************************************
    // 6312 kHz square wave generator
    // ****************************************
    logic [31:0] nco_acc; // phase accumulator

    // top bit of a phase accumulator gives a near 50% duty square wave
    always_ff @(posedge clock) begin
        if (reset) begin
            nco_acc <= 32'h0000_0000;
        end else begin
            nco_acc <= nco_acc + loop_sync_pkg::NCO_INC; // R15
        end
    end

    // ****************************************
    // composite clock receiver
    // ****************************************
    logic mark_pos, mark_neg; // mark starts
    logic rx_last_pol; // polarity of last received mark
    logic [3:0] rx_marks; // marks since last violation
    logic rx_8k_reg, rx_400_reg; // recovered references

    assign mark_pos = rx_s2.pos && !rx_s3.pos;
    assign mark_neg = rx_s2.neg && !rx_s3.neg;

    // a repeated polarity is a violation (8k); a missed one marks 400 Hz
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_last_pol <= 1'b0;
            rx_marks <= 4'h0;
            rx_8k_reg <= 1'b0;
            rx_400_reg <= 1'b0;
        end else if (mark_pos || mark_neg) begin
            rx_last_pol <= mark_pos;
            rx_8k_reg <= (mark_pos == rx_last_pol); // R8
            rx_400_reg <= (mark_pos != rx_last_pol) && (rx_marks == loop_sync_pkg::RX_MISS_MARKS);
            if (mark_pos == rx_last_pol || rx_marks == loop_sync_pkg::RX_MISS_MARKS) begin
                rx_marks <= 4'h0;
            end else begin
                rx_marks <= rx_marks + 4'h1;
            end
        end
    end

    // ****************************************
    // loopback data paths
    // ****************************************
    loop_sync_pkg::ami_s tx_src; // what the transmitter would send
    loop_sync_pkg::ami_s ja_reg; // attenuator retiming stage
    loop_sync_pkg::ami_s rx_src; // what the framer should see

    // formatter or composite generator feeds the local path
    assign tx_src = is_cc ? cc_tx : tx_fmt;

    // stand-in for the attenuator: one retiming stage in the loop path
    always_ff @(posedge clock) begin
        if (reset) begin
            ja_reg <= '0;
        end else begin
            ja_reg <= tx_src;
        end
    end

    // local loop swaps line receive for transmit data
    always_comb begin
        if (local_loop) begin
            rx_src = ja_active ? ja_reg : tx_src; // R3 R4
        end else begin
            rx_src = rx_s2;
        end
    end

    // framer keeps receiving during remote loop; a 6312 square input is just a level
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_frm <= '0;
        end else begin
            rx_frm <= rx_src; // R2 R12
        end
    end

    // transmit line: remote loop wins, formatter output is dropped
    always_ff @(posedge clock) begin
        if (reset) begin
            line_tx <= '0;
            line_tx_oe <= 1'b0;
        end else begin
            line_tx <= remote_loop ? rx_s2 : tx_src; // R1 R2
            line_tx_oe <= !is_sq; // R18
        end
    end

    // ****************************************
    // clock and reference outputs
    // ****************************************
    logic rx_clk_now; // recovered receive clock
    assign rx_clk_now = is_sq ? rx_s2.pos : (rx_s2.pos || rx_s2.neg); // R13

    // clock pins; 6312 sends the square wave, not a sinusoid
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_clock_out <= 1'b0;
            tx_clock_out <= 1'b0;
            pll_clock_out <= 1'b0;
        end else begin
            rx_clock_out <= rx_clk_now;
            pll_clock_out <= nco_acc[31]; // R11
            tx_clock_out <= remote_loop ? rx_clk_now : nco_acc[31]; // R16
        end
    end

    // references released in 6312 mode
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_sync_8k_out <= 1'b0;
            rx_400hz_out <= 1'b0;
            rx_sync_8k_oe <= 1'b0;
            rx_400hz_oe <= 1'b0;
        end else begin
            rx_sync_8k_out <= rx_8k_reg && is_cc;
            rx_400hz_out <= rx_400_reg && is_cc;
            rx_sync_8k_oe <= !is_sq; // R14
            rx_400hz_oe <= !is_sq; // R14
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (reset || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                loop_sync_pkg::LOOP_CTRL_ADDR: reg_rdata <= loop_ctrl_reg;
                loop_sync_pkg::SYNC_CFG_ADDR: reg_rdata <= sync_cfg_reg;
                loop_sync_pkg::STATUS_ADDR: begin
                    reg_rdata <= {2'h0, rx_400_reg, rx_8k_reg, sdata_s2 && !is_sq, // R17
                        ja_active, mode_reg};
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_remote_loop_path: assert property (@(posedge clock) disable iff (reset) // R1
        remote_loop |=> line_tx == $past(rx_s2))
        else $error("remote loop data not on transmit line");

    a_local_loop_path: assert property (@(posedge clock) disable iff (reset) // R3
        local_loop && !ja_active |=> rx_frm == $past(tx_src))
        else $error("local loop data not at framer");

    a_ja_loop_path: assert property (@(posedge clock) disable iff (reset) // R4
        local_loop && ja_active |=> rx_frm == $past(tx_src, 2))
        else $error("attenuator missing from local loop");

    a_frm_normal: assert property (@(posedge clock) disable iff (reset) // R2
        !local_loop |=> rx_frm == $past(rx_s2))
        else $error("framer lost receive data");

    a_ja_mode_gate: assert property (@(posedge clock) disable iff (reset) // R19
        (is_cc || is_sq) |-> !ja_active)
        else $error("attenuator active in sync mode");

    a_sq_tx_hiz: assert property (@(posedge clock) disable iff (reset) // R18
        is_sq ##1 is_sq |-> !line_tx_oe)
        else $error("transmit line driven in 6312 mode");

    a_sq_ref_hiz: assert property (@(posedge clock) disable iff (reset) // R14
        is_sq ##1 is_sq |-> !rx_sync_8k_oe && !rx_400hz_oe)
        else $error("references driven in 6312 mode");

    a_tclk_select: assert property (@(posedge clock) disable iff (reset) // R16
        ##1 tx_clock_out == ($past(remote_loop) ? rx_clock_out : pll_clock_out))
        else $error("transmit clock source wrong");

    a_cc_sync_align: assert property (@(posedge clock) disable iff (reset) // R9
        sync_edge |=> cc_cnt == 9'h000 && cc_bit == 3'h0 ##1 cc_cnt == 9'h001)
        else $error("violation not aligned to reference");

    a_loop_reset: assert property (@(posedge clock) // R21
        reset |=> !remote_loop && !local_loop)
        else $error("loop bits not cleared by reset");

endmodule

/* verification/line_far_end.sv */
// far-end line model: data pattern, composite clock or square-wave source
`timescale 1ns/1ns
module line_far_end (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // source: 0 data pattern, 1 composite clock, 2 square wave
    input wire logic [1:0] sel,
    // line towards the device receiver
    output loop_sync_pkg::ami_s line_rx
);
    logic [8:0] bit_cnt; // cycles inside one composite bit
    logic [2:0] bit_idx; // bit inside the 8k frame
    logic [4:0] frame_idx; // frame inside the 400 Hz superframe
    logic pol; // polarity of the current mark
    logic [7:0] pat; // free-running pattern
    logic mark; // mark window of the composite bit

    // composite timing: one mark a bit, violation on bit 0, dropped in the last frame
    always_ff @(posedge clock) begin
        if (reset) begin
            bit_cnt <= 9'h000;
            bit_idx <= 3'h0;
            frame_idx <= 5'h00;
            pol <= 1'b0;
            pat <= 8'h00;
        end else begin
            pat <= pat + 8'h01;
            if (bit_cnt == loop_sync_pkg::CC_BIT_LAST) begin
                bit_cnt <= 9'h000;
                bit_idx <= bit_idx + 3'h1;
                if (bit_idx == loop_sync_pkg::CC_BIT_IDX_LAST) begin
                    frame_idx <= (frame_idx == loop_sync_pkg::CC_FRAME_LAST) ? 5'h00 :
                        frame_idx + 5'h01;
                end
            end else begin
                bit_cnt <= bit_cnt + 9'h001;
            end
            // keeping the polarity on bit 0 makes the violation
            if (bit_cnt == 9'h000 &&
                !(bit_idx == 3'h0 && frame_idx != loop_sync_pkg::CC_FRAME_LAST)) begin
                pol <= ~pol;
            end
        end
    end

    // mark starts one cycle late so the new polarity is already settled
    assign mark = (bit_cnt != 9'h000) && (bit_cnt <= loop_sync_pkg::CC_HALF);

    // line levels for the selected source
    always_comb begin
        case (sel)
            2'h1: line_rx = '{pos: mark & pol, neg: mark & ~pol};
            2'h2: line_rx = '{pos: pat[1], neg: ~pat[1]};
            default: line_rx = '{pos: pat[0] ^ pat[3], neg: pat[2]};
        endcase
    end
endmodule

/* verification/tb.sv */
// self-checking bench for the loopback and sync-clock block
`timescale 1ns/1ns
module tb;
    // ****************
    // signals
    // ****************
    logic clock, reset, reg_wr, reg_rd, serial_data_in, tx_sync_8k_in, last_pol;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] sel; // far-end source
    logic [2:0] fmt_cnt; // formatter pattern
    logic [4:0] p_clk; // previous 400, 8k, rx, tx, pll levels
    loop_sync_pkg::line_mode_e line_mode;
    loop_sync_pkg::ami_s line_rx, line_tx, tx_fmt, rx_frm, p_tx;
    loop_sync_pkg::ami_s h_rx [0:2]; // receive history, newest first
    loop_sync_pkg::ami_s h_fmt [0:1]; // formatter history
    logic line_tx_oe, rx_sync_8k_out, rx_sync_8k_oe, rx_400hz_out, rx_400hz_oe;
    logic rx_clock_out, tx_clock_out, pll_clock_out;
    int cnt [8]; // event counters: pll rise, pll high, tx rise, rx rise, viol, 8k, 400, marks
    int s [8];
    int dl [8]; // events inside the last window
    int cyc, viol_cyc, t0, i, error_cnt, check_count;

    loop_sync_interface u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_mode(line_mode), .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe),
        .tx_fmt(tx_fmt), .rx_frm(rx_frm), .serial_data_in(serial_data_in),
        .tx_sync_8k_in(tx_sync_8k_in), .rx_sync_8k_out(rx_sync_8k_out),
        .rx_sync_8k_oe(rx_sync_8k_oe), .rx_400hz_out(rx_400hz_out), .rx_400hz_oe(rx_400hz_oe),
        .rx_clock_out(rx_clock_out), .tx_clock_out(tx_clock_out),
        .pll_clock_out(pll_clock_out));
    line_far_end u_far (.clock(clock), .reset(reset), .sel(sel), .line_rx(line_rx));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // history, event counters and hang guard; counts are read as differences only
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fmt_cnt <= fmt_cnt + 3'h1;
        tx_fmt <= '{pos: fmt_cnt[1], neg: fmt_cnt[0] ^ fmt_cnt[2]};
        h_rx <= '{line_rx, h_rx[0], h_rx[1]};
        h_fmt <= '{tx_fmt, h_fmt[0]};
        p_clk <= {rx_400hz_out, rx_sync_8k_out, rx_clock_out, tx_clock_out, pll_clock_out};
        p_tx <= line_tx;
        if (pll_clock_out & ~p_clk[0]) cnt[0] <= cnt[0] + 1;
        if (pll_clock_out) cnt[1] <= cnt[1] + 1;
        if (tx_clock_out & ~p_clk[1]) cnt[2] <= cnt[2] + 1;
        if (rx_clock_out & ~p_clk[2]) cnt[3] <= cnt[3] + 1;
        if (rx_sync_8k_out & ~p_clk[3]) cnt[5] <= cnt[5] + 1;
        if (rx_400hz_out & ~p_clk[4]) cnt[6] <= cnt[6] + 1;
        // a mark of the same polarity as the one before is a violation
        if ((line_tx.pos & ~p_tx.pos) | (line_tx.neg & ~p_tx.neg)) begin
            cnt[7] <= cnt[7] + 1;
            last_pol <= line_tx.pos;
            if (line_tx.pos == last_pol) begin
                cnt[4] <= cnt[4] + 1;
                viol_cyc <= cyc;
            end
        end
        // tests take about 66000 cycles
        if (cyc == 90000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic run(input int n);
        s = cnt;
        step(n);
        foreach (dl[k]) dl[k] = cnt[k] - s[k];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************
    // tests
    // ****************
    initial begin
        foreach (cnt[k]) cnt[k] = 0;
        {reset, reg_wr, reg_rd, serial_data_in, tx_sync_8k_in} = 5'h12;
        {reg_addr, reg_wdata, sel, fmt_cnt, p_clk, last_pol} = 27'h0;
        {tx_fmt, p_tx, cyc, viol_cyc, error_cnt, check_count} = '0;
        line_mode = loop_sync_pkg::mode_t1;
        step(10);
        reset <= 1'b0;
        rd(loop_sync_pkg::LOOP_CTRL_ADDR);
        chk("loop reset", d, loop_sync_pkg::LOOP_CTRL_RESET);
        rd(loop_sync_pkg::SYNC_CFG_ADDR);
        chk("sync reset", d, loop_sync_pkg::SYNC_CFG_RESET);
        wr(8'h30, 8'h5a);
        rd(8'h30);
        chk("unmapped", d, 8'h00);
        // remote loop: line receive goes back out, framer still fed
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h04);
        rd(loop_sync_pkg::LOOP_CTRL_ADDR);
        chk("loop readback", d, 8'h04);
        step(3);
        for (i = 0; i < 6; i++) begin
            step(1);
            chk("remote line_tx", line_tx, h_rx[2]);
            chk("remote rx_frm", rx_frm, h_rx[2]);
        end
        // local loop, first plain and then through the attenuator
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h08);
        step(3);
        for (i = 0; i < 6; i++) begin
            step(1);
            chk("local line_tx", line_tx, h_fmt[0]);
            chk("local rx_frm", rx_frm, h_fmt[0]);
        end
        wr(loop_sync_pkg::SYNC_CFG_ADDR, 8'h02);
        step(3);
        for (i = 0; i < 6; i++) begin
            step(1);
            chk("attenuated rx_frm", rx_frm, h_fmt[1]);
        end
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h00);
        // every mode: status, enables and attenuator availability
        for (i = 0; i < 4; i++) begin
            @(posedge clock) line_mode <= loop_sync_pkg::line_mode_e'(i);
            step(4);
            rd(loop_sync_pkg::STATUS_ADDR);
            chk("status mode", d[1:0], i);
            chk("status attenuator", d[2], i < 2);
            chk("status serial", d[3], i != 3);
            chk("line oe", line_tx_oe, i != 3);
            chk("8k oe", rx_sync_8k_oe, i != 3);
            chk("400 oe", rx_400hz_oe, i != 3);
        end
        // 6312 mode, square wave of period 4 from the far end
        wr(loop_sync_pkg::SYNC_CFG_ADDR, 8'h00);
        sel <= 2'h2;
        step(20);
        run(1000);
        chk("pll rises", dl[0] >= 315 && dl[0] <= 316, 1);
        chk("pll duty", dl[1] >= 497 && dl[1] <= 503, 1);
        chk("tx clock mirror", dl[2] >= dl[0] - 1 && dl[2] <= dl[0] + 1, 1);
        chk("rx clock rises", dl[3] >= 249 && dl[3] <= 251, 1);
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h04);
        step(5);
        run(1000);
        chk("tx clock looped", dl[2] >= 249 && dl[2] <= 251, 1);
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h00);
        // composite clock with 400 Hz variant, no sync reference
        @(posedge clock) line_mode <= loop_sync_pkg::mode_cc64;
        sel <= 2'h1;
        wr(loop_sync_pkg::SYNC_CFG_ADDR, 8'h01);
        step(2600);
        run(49920);
        chk("tx marks", dl[7], 160);
        chk("tx violations", dl[4], 19);
        chk("rx 8k", dl[5], 19);
        chk("rx 400", dl[6], 1);
        wr(loop_sync_pkg::SYNC_CFG_ADDR, 8'h00);
        step(2600);
        run(4992);
        chk("tx violations plain", dl[4], 2);
        // sync reference edge, well away from the free-running violation
        t0 = cnt[4];
        for (i = 0; i < 2600 && cnt[4] == t0; i++) step(1);
        step(1000);
        t0 = cyc;
        tx_sync_8k_in <= 1'b1;
        step(20);
        chk("sync aligned", viol_cyc - t0 >= 1 && viol_cyc - t0 <= 12, 1);
        tx_sync_8k_in <= 1'b0;
        // second reset clears both loop bits
        wr(loop_sync_pkg::LOOP_CTRL_ADDR, 8'h0c);
        rd(loop_sync_pkg::LOOP_CTRL_ADDR);
        chk("both loops", d, 8'h0c);
        reset <= 1'b1;
        step(3);
        reset <= 1'b0;
        rd(loop_sync_pkg::LOOP_CTRL_ADDR);
        chk("loop after reset", d, 8'h00);
        final_report();
    end
endmodule
